//--- core/aiu_consts.svh
// constants for the alarm indication unit
`ifndef AIU_CONSTS_SVH
`define AIU_CONSTS_SVH

`define AIU_CLK_HZ           50000000
`define AIU_FAST_HZ          4
`define AIU_SLOW_HZ          1
// half period counts for the blink generators
`define AIU_FAST_HALF        (`AIU_CLK_HZ / (2 * `AIU_FAST_HZ))
`define AIU_SLOW_HALF        (`AIU_CLK_HZ / (2 * `AIU_SLOW_HZ))

// register offsets
`define AIU_REG_CTRL         4'h0
`define AIU_REG_STATUS       4'h1
`define AIU_REG_CODE         4'h2
`define AIU_REG_LEVEL        4'h3

// control register bits
`define AIU_CTRL_CLEAR       0
`define AIU_CTRL_RELAY_INV   1
`define AIU_CTRL_START       2

// level codes, millivolts on the 0..10 V actual-value output
`define AIU_MV_FULL          14'd10000
`define AIU_MV_101           14'd660
`define AIU_MV_102           14'd1330
`define AIU_MV_103           14'd2000
`define AIU_MV_STEP          14'd2660
`define AIU_MV_LINE          14'd3330
`define AIU_MV_HEAT          14'd4000
`define AIU_MV_INT           14'd4660
`define AIU_MV_SIG           14'd5330
`define AIU_MV_DATA          14'd6000
`define AIU_MV_111           14'd6660
`define AIU_MV_112           14'd7330
`define AIU_MV_113           14'd8000
`define AIU_MV_115           14'd8660

`endif

//--- core/aiu_pkg.sv
// types for the alarm indication unit
package aiu_pkg;
    typedef enum logic [1:0] {
        AIU_LAMP_OFF,
        AIU_LAMP_FAST,
        AIU_LAMP_SLOW,
        AIU_LAMP_STEADY
    } aiu_lamp_e;

    typedef logic [9:0]  aiu_code_t;
    typedef logic [13:0] aiu_mv_t;
endpackage

//--- core/aiu_blink.sv
// square wave generator toggling every half period
`timescale 1ns/1ns
`include "aiu_consts.svh"
module aiu_blink #(
    parameter int HALF = 6250000
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      wave
);
    logic [31:0] cnt_q;
    logic        wave_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 32'h0;
            wave_q <= 1'b0;
        end else if (cnt_q == 32'(HALF - 1)) begin
            cnt_q <= 32'h0;
            wave_q <= ~wave_q;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    assign wave = wave_q;
endmodule

//--- core/aiu_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module aiu_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end

    assign q = s2_q;
endmodule

//--- core/aiu_top.sv
// alarm indication unit: lamp, relay, fieldbus flags and level output
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "aiu_consts.svh"
module aiu_top #(
    parameter int FAST_HALF = `AIU_FAST_HALF,
    parameter int SLOW_HALF = `AIU_SLOW_HALF
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                err_valid,
    input  wire aiu_pkg::aiu_code_t  err_code,
    input  wire logic [13:0]         temp_mv,
    input  wire logic                start_pin,
    input  wire logic [3:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [31:0]         reg_rdata,
    output logic                     lamp,
    output logic                     relay,
    output logic                     alarm_flag,
    output logic                     warning_flag,
    output logic      [15:0]         status_word3,
    output aiu_pkg::aiu_mv_t         level_mv
);

    ////////////////////////////////////////////////////////////////////////
    // code classification

    function automatic logic is_fast(input aiu_pkg::aiu_code_t c);
        return (c >= 10'd104 && c <= 10'd106) || c == 10'd211 ||
               c == 10'd302 || c == 10'd303;
    endfunction

    function automatic logic is_slow(input aiu_pkg::aiu_code_t c);
        return c >= 10'd111 && c <= 10'd114;
    endfunction

    function automatic logic is_fault(input aiu_pkg::aiu_code_t c);
        return (c >= 10'd101 && c <= 10'd103) || c == 10'd107 || c == 10'd108 ||
               (c >= 10'd201 && c <= 10'd203) || c == 10'd304 || c == 10'd307 ||
               c == 10'd308 || (c >= 10'd900 && c <= 10'd999);
    endfunction

    function automatic aiu_pkg::aiu_mv_t code_level(input aiu_pkg::aiu_code_t c);
        aiu_pkg::aiu_mv_t v;
        v = `AIU_MV_INT;
        case (c)
            10'd101: v = `AIU_MV_101;
            10'd102: v = `AIU_MV_102;
            10'd103: v = `AIU_MV_103;
            10'd107, 10'd108, 10'd307, 10'd308,
            10'd309, 10'd310: v = `AIU_MV_STEP;
            10'd201, 10'd202, 10'd203: v = `AIU_MV_LINE;
            10'd304: v = `AIU_MV_HEAT;
            10'd104, 10'd105, 10'd106,
            10'd302, 10'd303: v = `AIU_MV_SIG;
            10'd211: v = `AIU_MV_DATA;
            10'd111: v = `AIU_MV_111;
            10'd112: v = `AIU_MV_112;
            10'd113, 10'd114: v = `AIU_MV_113;
            10'd115, 10'd116: v = `AIU_MV_115;
            default: v = `AIU_MV_INT;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // inputs and control register

    logic start_s;
    logic clear_q;
    logic relay_inv_q;
    logic sw_start_q;
    logic fast_wave;
    logic slow_wave;

    // start pin is asynchronous to clk
    aiu_sync #(.W(1)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (start_pin),
        .q     (start_s)
    );

    aiu_blink #(.HALF(FAST_HALF)) u_fast (
        .clk   (clk),
        .rst_n (rst_n),
        .wave  (fast_wave)
    );

    aiu_blink #(.HALF(SLOW_HALF)) u_slow (
        .clk   (clk),
        .rst_n (rst_n),
        .wave  (slow_wave)
    );

    ////////////////////////////////////////////////////////////////////////
    // control register, one field per process

    logic ctrl_wr;
    assign ctrl_wr = reg_wr && reg_addr == `AIU_REG_CTRL;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clear_q <= 1'b0;
        end else if (ctrl_wr) begin
            clear_q <= reg_wdata[`AIU_CTRL_CLEAR];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            relay_inv_q <= 1'b0;
        end else if (ctrl_wr) begin
            relay_inv_q <= reg_wdata[`AIU_CTRL_RELAY_INV];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sw_start_q <= 1'b0;
        end else if (ctrl_wr) begin
            sw_start_q <= reg_wdata[`AIU_CTRL_START];
        end
    end

    logic start_any;
    assign start_any = start_s | sw_start_q;

    ////////////////////////////////////////////////////////////////////////
    // error latch

    logic               active_q;
    aiu_pkg::aiu_code_t code_q;
    logic               started_q;
    logic               clear_fall;
    logic               clear_prev_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clear_prev_q <= 1'b0;
        end else begin
            clear_prev_q <= clear_q;
        end
    end

    // clear acts on release of the bit, not on setting it
    assign clear_fall = clear_prev_q & ~clear_q;

    // power cycle clears via rst_n
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            active_q <= 1'b0;
        end else if (!active_q && err_valid) begin
            active_q <= 1'b1;
        end else if (active_q && clear_fall) begin
            active_q <= 1'b0;
        end
    end

    // later codes ignored while one is held
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            code_q <= 10'h000;
        end else if (!active_q && err_valid) begin
            code_q <= err_code;
        end else if (active_q && clear_fall) begin
            code_q <= 10'h000;
        end
    end

    // warning becomes fault once start is seen
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            started_q <= 1'b0;
        end else if (!active_q) begin
            started_q <= 1'b0;
        end else if (start_any) begin
            started_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lamp state

    aiu_pkg::aiu_lamp_e lamp_state;
    logic               is_warn;

    assign is_warn = is_fast(code_q) | is_slow(code_q);

    always_comb begin
        lamp_state = aiu_pkg::AIU_LAMP_OFF;
        if (active_q) begin
            if (started_q) begin
                lamp_state = aiu_pkg::AIU_LAMP_STEADY;
            end else if (is_fast(code_q)) begin
                lamp_state = aiu_pkg::AIU_LAMP_FAST;
            end else if (is_slow(code_q)) begin
                lamp_state = aiu_pkg::AIU_LAMP_SLOW;
            end else if (is_fault(code_q)) begin
                lamp_state = aiu_pkg::AIU_LAMP_STEADY;
            end else begin
                // unlisted codes are treated as faults
                lamp_state = aiu_pkg::AIU_LAMP_STEADY;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    logic             lamp_d;
    logic             relay_d;
    aiu_pkg::aiu_mv_t level_d;

    always_comb begin
        case (lamp_state)
            aiu_pkg::AIU_LAMP_FAST: begin
                lamp_d = fast_wave;
                relay_d = 1'b0;
            end
            aiu_pkg::AIU_LAMP_SLOW: begin
                lamp_d = slow_wave;
                relay_d = 1'b0;
            end
            aiu_pkg::AIU_LAMP_STEADY: begin
                lamp_d = 1'b1;
                relay_d = 1'b1;
            end
            default: begin
                lamp_d = 1'b0;
                relay_d = 1'b0;
            end
        endcase
    end

    // during an unstarted warning, full scale while slow wave high, error level while low
    always_comb begin
        if (!active_q) begin
            level_d = temp_mv;
        end else if (is_warn && !started_q && slow_wave) begin
            level_d = `AIU_MV_FULL;
        end else begin
            level_d = code_level(code_q);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lamp <= 1'b0;
        end else begin
            lamp <= lamp_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            relay <= 1'b0;
        end else begin
            relay <= relay_d ^ relay_inv_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            level_mv <= 14'h0000;
        end else begin
            level_mv <= level_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fieldbus flags and code word

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alarm_flag <= 1'b0;
        end else begin
            alarm_flag <= active_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            warning_flag <= 1'b0;
        end else begin
            warning_flag <= active_q & is_warn & ~started_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_word3 <= 16'h0000;
        end else begin
            status_word3 <= {6'h00, code_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read port
    // answer stands one cycle, zero otherwise

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `AIU_REG_CTRL:   reg_rdata <= {29'h0, sw_start_q, relay_inv_q, clear_q};
                `AIU_REG_STATUS: reg_rdata <= {26'h0, lamp_state, relay, started_q,
                                               warning_flag, alarm_flag};
                `AIU_REG_CODE:   reg_rdata <= {22'h0, code_q};
                `AIU_REG_LEVEL:  reg_rdata <= {18'h0, level_mv};
                default:         reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule

//--- test/aiu_checker.sv
// port assertions for the alarm indication unit
`timescale 1ns/1ns
module aiu_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        lamp,
    input wire logic        relay,
    input wire logic        alarm_flag,
    input wire logic        warning_flag,
    input wire logic [15:0] status_word3,
    input wire logic [13:0] level_mv,
    input wire logic [13:0] temp_mv
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    code_upper_a: assert property (status_word3[15:10] == 6'h00)
        else $error("code field upper bits set");
    alarm_code_a: assert property (alarm_flag |-> status_word3[9:0] != 10'h000)
        else $error("alarm without code");
    warn_alarm_a: assert property (warning_flag |-> alarm_flag)
        else $error("warning without alarm");
    code_held_a: assert property (
        alarm_flag && $past(alarm_flag) |-> $stable(status_word3))
        else $error("latched code changed");
    idle_level_a: assert property (!alarm_flag && !$past(alarm_flag) && $past(rst_n)
        |-> level_mv == $past(temp_mv))
        else $error("idle level not temperature");
    fault_lamp_a: assert property (alarm_flag && !warning_flag |-> lamp)
        else $error("fault lamp not steady");
    fault_level_a: assert property (alarm_flag && !warning_flag
        && $past(alarm_flag && !warning_flag) |-> $stable(level_mv))
        else $error("fault level moved");
    warn_toggle_a: assert property (
        warning_flag && $past(warning_flag) && $changed(level_mv)
        |-> (level_mv == 14'd10000) != ($past(level_mv) == 14'd10000))
        else $error("warning level not alternating with full scale");
    warn_relay_a: assert property (warning_flag && $past(warning_flag) |-> $stable(relay))
        else $error("relay moved during warning");
    read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside answer cycle");
endmodule

//--- test/aiu_plc_model.sv
// machine controller side: raises start after a request
`timescale 1ns/1ns
module aiu_plc_model #(
    parameter int DLY = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic alarm_flag,
    output logic     start_pin
);
    int   cnt_q = 0;
    logic st_q  = 1'b0;
    assign start_pin = st_q;
    always @(posedge clk) begin
        if (!rst_n)
            cnt_q <= 0;
        else if (go && alarm_flag)
            cnt_q <= DLY + 6;
        else if (cnt_q > 0)
            cnt_q <= cnt_q - 1;
        st_q <= rst_n && cnt_q > 0 && cnt_q <= 6;
    end
endmodule

//--- test/test_aiu_top.sv
// self-checking bench for the alarm indication unit
`timescale 1ns/1ns
module test_aiu_top;
    localparam int FH = 4;
    localparam int SH = 16;
    logic        clk = 0, rst_n = 0, err_valid = 0, reg_wr = 0, reg_rd = 0, go = 0;
    logic [9:0]  err_code = 0;
    logic [13:0] temp_mv = 0, level_mv;
    logic [3:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, rd_v;
    logic        start_pin, lamp, relay, alarm_flag, warning_flag;
    logic [15:0] status_word3;
    int          n_fail = 0, samples_checked = 0, seed = 91348;
    int          c, k, e, l, p, f;
    int          codes[22] = '{101, 102, 103, 107, 108, 201, 202, 203, 304, 307, 308,
                               915, 104, 105, 106, 211, 302, 303, 111, 112, 113, 114};
    initial forever #10 clk = ~clk;
    aiu_top #(.FAST_HALF(FH), .SLOW_HALF(SH)) u_aiu_top (.clk(clk), .rst_n(rst_n),
        .err_valid(err_valid), .err_code(err_code), .temp_mv(temp_mv), .start_pin(start_pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .lamp(lamp), .relay(relay), .alarm_flag(alarm_flag),
        .warning_flag(warning_flag), .status_word3(status_word3), .level_mv(level_mv));
    aiu_plc_model u_aiu_plc_model (.clk(clk), .rst_n(rst_n), .go(go),
        .alarm_flag(alarm_flag), .start_pin(start_pin));
    ////////////////////////////////////////////////////////////////
    function automatic int lvl(input int x);
        case (x)
            101: return 660;
            102: return 1330;
            103: return 2000;
            107, 108, 307, 308: return 2660;
            201, 202, 203: return 3330;
            304: return 4000;
            104, 105, 106, 302, 303: return 5330;
            211: return 6000;
            111: return 6660;
            112: return 7330;
            113, 114: return 8000;
            default: return 4660;
        endcase
    endfunction
    function automatic int knd(input int x);
        if (x >= 111 && x <= 114)
            return 2;
        if (x inside {104, 105, 106, 211, 302, 303})
            return 1;
        return 0;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checked=%0d failed=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        #1 rd_v = reg_rdata;
    endtask
    task automatic inj(input int x);
        @(posedge clk);
        err_valid <= 1;
        err_code <= 10'(x);
        temp_mv <= 14'($unsigned($random(seed)) % 10000);
        @(posedge clk);
        err_valid <= 0;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        cyc(10);
        rst_n <= 1;
        rd(4'h9);
        check(rd_v, 0);
        for (int v = 0; v < 2; v++) begin
            wr(0, v * 2);
            foreach (codes[i]) begin
                c = codes[i];
                k = knd(c);
                e = lvl(c);
                inj(c);
                cyc(3);
                #1;
                check(alarm_flag, 1);
                check(warning_flag, k != 0);
                check(status_word3, c);
                check(relay, (k == 0) ^ v);
                if (k == 0) begin
                    check(lamp, 1);
                    check(level_mv, e);
                end else begin
                    l = lamp;
                    p = 0;
                    f = 0;
                    for (int j = 1; j <= 40; j++) begin
                        @(posedge clk);
                        #1;
                        if (lamp !== l) begin
                            if (p > 0)
                                check(j - p, k == 1 ? FH : SH);
                            p = j;
                            l = lamp;
                        end
                        if (level_mv === 14'd10000)
                            f++;
                        else if (level_mv !== e)
                            check(level_mv, e);
                    end
                    check(f > 0 && f < 40, 1);
                    @(posedge clk);
                    go <= 1;
                    @(posedge clk);
                    go <= 0;
                    cyc(14);
                    #1;
                    check(warning_flag, 0);
                    check(lamp, 1);
                    check(relay, !v);
                    check(level_mv, e);
                end
                inj(codes[$unsigned($random(seed)) % 22]);
                cyc(3);
                rd(2);
                check(rd_v, c);
                rd(3);
                check(rd_v, e);
                check(status_word3, c);
                wr(0, v * 2 + 1);
                cyc(4);
                #1;
                check(alarm_flag, 1);
                wr(0, v * 2);
                cyc(4);
                #1;
                check(alarm_flag, 0);
                check(level_mv, temp_mv);
                check(relay, v);
            end
        end
        inj(111);
        cyc(3);
        #1;
        check(warning_flag, 1);
        wr(0, 6);
        cyc(3);
        #1;
        check(warning_flag, 0);
        check(lamp, 1);
        check(relay, 0);
        check(level_mv, lvl(111));
        check(alarm_flag, 1);
        cyc(1);
        rst_n <= 0;
        cyc(3);
        rst_n <= 1;
        cyc(2);
        #1;
        check(alarm_flag, 0);
        check(relay, 0);
        check(level_mv, temp_mv);
        report_and_stop;
    end
    initial begin
        #400000;
        n_fail++;
        report_and_stop;
    end
endmodule
bind aiu_top aiu_checker u_aiu_checker (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lamp(lamp), .relay(relay), .alarm_flag(alarm_flag),
    .warning_flag(warning_flag), .status_word3(status_word3), .level_mv(level_mv),
    .temp_mv(temp_mv));
